// *** msc_mode_supply_regs.sv ***
// Mode and supply control registers with their device-side effects.
`timescale 1ns/1ps
// What this block does
// - Mode field: normal, sleep, stop, soft reset.
// - Reserved bits always read back zero.
// - Aux regulator policy: off, normal, +stop, always.
// - Aux off in restart, fail-safe, init unless dev.
// - Overvoltage sets flag; reaction bit enables restart or fail-safe.
// - Two-bit field selects one of four thresholds.
// - Stop to sleep write is not honoured.
// - Stop to normal ignores low bits, flags if they differ.
// - Restart entry sets mode field to normal.
// - Restart or overtemperature clears aux policy.
// - Write frame returns previous register contents.
// - Development mode powers up aux always on.
// - Reset zeroes; restart keeps threshold bits.
// - Soft reset pulses reset pin unless configured.
// - Software forces fail output when pin configured.
// - Charge pump follows its enable bit.
// - Select bit chooses first or second watchdog failure.
// - Clearing force bit keeps failure-raised fail output.
// - Restart clears software fail force bit.
// - Locked bits survive soft reset.
// - Locked bits reject writes.
// - Soft reset restores unlocked fields.
module msc_mode_supply_regs (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic sdi_i,
  output logic sdo_o,
  // Current device state
  input wire logic dev_mode_i,
  input wire logic init_mode_i,
  input wire logic normal_mode_i,
  input wire logic stop_mode_i,
  input wire logic restart_mode_i,
  input wire logic failsafe_mode_i,
  input wire logic restart_entry_i,
  input wire logic overtemp_i,
  input wire logic hw_cfg_restart_i,
  // Locks held elsewhere in the map
  input wire logic cfg_lock0_i,
  input wire logic cfg_lock1_i,
  // Supervision events
  input wire logic main_ov_i,
  input wire logic main_ov_flag_clr_i,
  input wire logic wd_fail_i,
  input wire logic wd_ok_i,
  input wire logic failure_i,
  input wire logic fo_pin_cfg_i,
  // Mode and supply outputs
  output logic [1:0] mode_req_o,
  output logic soft_reset_o,
  output logic reset_output_pin_n_o,
  output logic aux_regulator_on_o,
  output logic [1:0] main_reset_threshold_sel_o,
  output logic main_overvoltage_flag_o,
  output logic restart_req_o,
  output logic failsafe_req_o,
  output logic spi_fail_set_o,
  output logic fail_output_pin_o,
  output logic charge_pump_enable_o
);
  import msc_pkg::*;

  // ****************
  // Aux regulator decision
  // ****************
  function automatic logic aux_allowed(input logic [1:0] pol,
                                       input logic normal,
                                       input logic stop);
    case (pol)
      MSC_AUX_NORMAL: aux_allowed = normal;
      MSC_AUX_NORM_STOP: aux_allowed = normal | stop;
      MSC_AUX_ALWAYS: aux_allowed = 1'b1;
      default: aux_allowed = 1'b0;
    endcase
  endfunction

  // ****************
  // Register state
  // ****************
  logic [1:0] mode_field;
  logic [1:0] aux_regulator_policy;
  logic main_overvoltage_reaction;
  logic [1:0] main_reset_threshold_sel;
  logic soft_reset_rst_cfg;
  logic sw_fail_output_force;
  logic charge_pump_enable;
  logic watchdog_fail_count_sel;
  logic por_pending;
  logic main_ov_q;
  logic [1:0] wd_fail_cnt;
  logic [7:0] srst_cnt;

  logic [6:0] rd_addr;
  msc_frame_t frame;
  logic frame_valid;
  logic [7:0] rd_data;

  msc_spi_slave u_spi (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .sclk_i(sclk_i),
    .csn_i(csn_i),
    .sdi_i(sdi_i),
    .sdo_o(sdo_o),
    .rd_data_i(rd_data),
    .rd_addr_o(rd_addr),
    .frame_o(frame),
    .frame_valid_o(frame_valid)
  );

  // ****************
  // Readback and write decode
  // ****************
  wire [7:0] mode_rd = {mode_field, 1'b0, aux_regulator_policy,
                        main_overvoltage_reaction,
                        main_reset_threshold_sel};
  wire [7:0] hw_rd = {1'b0, soft_reset_rst_cfg, sw_fail_output_force,
                      2'b00, charge_pump_enable, 1'b0,
                      watchdog_fail_count_sel};
  assign rd_data = (rd_addr == MSC_ADDR_MODE_SUPPLY) ? mode_rd :
                   (rd_addr == MSC_ADDR_HW_CTRL_LOW) ? hw_rd :
                   8'h00;

  wire wr_mode = frame_valid & frame.write &
                 (frame.addr == MSC_ADDR_MODE_SUPPLY);
  wire wr_hw = frame_valid & frame.write &
               (frame.addr == MSC_ADDR_HW_CTRL_LOW);
  wire [1:0] wr_mode_val = frame.data[MSC_MODE_HI:MSC_MODE_LO];
  wire stop_to_sleep = wr_mode & stop_mode_i &
                       (wr_mode_val == MSC_MODE_SLEEP);
  wire stop_to_normal = wr_mode & stop_mode_i &
                        (wr_mode_val == MSC_MODE_NORMAL);
  wire low_changed = frame.data[4:0] != mode_rd[4:0];
  wire soft_reset = wr_mode & (wr_mode_val == MSC_MODE_SRESET);
  wire low_accept = wr_mode & ~stop_to_normal & ~soft_reset;
  wire mode_accept = wr_mode & ~stop_to_sleep & ~soft_reset;

  // ****************
  // Supervision decode
  // ****************
  wire ov_rise = main_ov_i & ~main_ov_q;
  wire ov_react = ov_rise & main_overvoltage_reaction;
  wire [1:0] wd_need = watchdog_fail_count_sel ? 2'h1 : 2'h2;
  wire [1:0] wd_next = wd_fail_cnt + 2'h1;
  wire wd_react = wd_fail_i & (wd_next >= wd_need);
  wire go_restart = ov_react | wd_react;

  wire aux_block = restart_mode_i | failsafe_mode_i |
                   (init_mode_i & ~dev_mode_i);
  wire next_aux_on = ~aux_block &
                     aux_allowed(aux_regulator_policy, normal_mode_i,
                                 stop_mode_i);
  wire next_fail_out = (sw_fail_output_force & fo_pin_cfg_i) |
                       failure_i;

  // ****************
  // Mode and supply register
  // ****************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mode_field <= MSC_MODE_SUPPLY_RST[MSC_MODE_HI:MSC_MODE_LO];
      aux_regulator_policy <= MSC_AUX_OFF;
      main_overvoltage_reaction <= MSC_MODE_SUPPLY_RST[MSC_OVR_BIT];
      main_reset_threshold_sel <= MSC_MODE_SUPPLY_RST[MSC_RT_HI:MSC_RT_LO];
      por_pending <= 1'b1;
    end else begin
      por_pending <= 1'b0;
      if (por_pending) begin
        aux_regulator_policy <= dev_mode_i ?
                                MSC_AUX_DEV_RST : MSC_AUX_OFF;
      end
      if (restart_entry_i) begin
        mode_field <= MSC_MODE_NORMAL;
        aux_regulator_policy <= MSC_AUX_OFF;
        main_overvoltage_reaction <= 1'b0;
      end else if (soft_reset) begin
        mode_field <= MSC_MODE_SUPPLY_RST[MSC_MODE_HI:MSC_MODE_LO];
        aux_regulator_policy <= MSC_AUX_OFF;
        main_overvoltage_reaction <= MSC_MODE_SUPPLY_RST[MSC_OVR_BIT];
        main_reset_threshold_sel <=
          MSC_MODE_SUPPLY_RST[MSC_RT_HI:MSC_RT_LO];
      end else begin
        if (mode_accept) begin
          mode_field <= wr_mode_val;
        end
        if (low_accept) begin
          aux_regulator_policy <=
            frame.data[MSC_AUX_HI:MSC_AUX_LO];
          main_overvoltage_reaction <= frame.data[MSC_OVR_BIT];
          main_reset_threshold_sel <=
            frame.data[MSC_RT_HI:MSC_RT_LO];
        end
        if (overtemp_i) begin
          aux_regulator_policy <= MSC_AUX_OFF;
        end
      end
    end
  end

  // ****************
  // Hardware control register
  // ****************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      soft_reset_rst_cfg <= MSC_HW_CTRL_LOW_RST[MSC_SRST_BIT];
      sw_fail_output_force <= MSC_HW_CTRL_LOW_RST[MSC_FO_BIT];
      charge_pump_enable <= MSC_HW_CTRL_LOW_RST[MSC_CP_BIT];
      watchdog_fail_count_sel <= MSC_HW_CTRL_LOW_RST[MSC_WDSEL_BIT];
    end else if (restart_entry_i) begin
      sw_fail_output_force <= 1'b0;
    end else if (soft_reset) begin
      if (!cfg_lock1_i) begin
        soft_reset_rst_cfg <= MSC_HW_CTRL_LOW_RST[MSC_SRST_BIT];
      end
      if (!cfg_lock0_i) begin
        charge_pump_enable <= MSC_HW_CTRL_LOW_RST[MSC_CP_BIT];
      end
      sw_fail_output_force <= MSC_HW_CTRL_LOW_RST[MSC_FO_BIT];
      watchdog_fail_count_sel <= MSC_HW_CTRL_LOW_RST[MSC_WDSEL_BIT];
    end else if (wr_hw) begin
      if (!cfg_lock1_i) begin
        soft_reset_rst_cfg <= frame.data[MSC_SRST_BIT];
      end
      if (!cfg_lock0_i) begin
        charge_pump_enable <= frame.data[MSC_CP_BIT];
      end
      sw_fail_output_force <= frame.data[MSC_FO_BIT];
      watchdog_fail_count_sel <= frame.data[MSC_WDSEL_BIT];
    end
  end

  // ****************
  // Overvoltage flag and watchdog failure count
  // ****************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      main_ov_q <= 1'b0;
      main_overvoltage_flag_o <= 1'b0;
      wd_fail_cnt <= 2'h0;
    end else begin
      main_ov_q <= main_ov_i;
      // Set wins over a clear in the same cycle
      if (ov_rise) begin
        main_overvoltage_flag_o <= 1'b1;
      end else if (main_ov_flag_clr_i) begin
        main_overvoltage_flag_o <= 1'b0;
      end
      if (wd_react || wd_ok_i || restart_entry_i) begin
        wd_fail_cnt <= 2'h0;
      end else if (wd_fail_i) begin
        wd_fail_cnt <= wd_next;
      end
    end
  end

  // ****************
  // Soft reset pulse on the reset pin
  // ****************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      srst_cnt <= 8'h00;
      reset_output_pin_n_o <= 1'b1;
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= soft_reset;
      if (soft_reset && !soft_reset_rst_cfg) begin
        srst_cnt <= 8'(MSC_SRST_PULSE_CYC);
        reset_output_pin_n_o <= 1'b0;
      end else if (srst_cnt > 8'h01) begin
        srst_cnt <= srst_cnt - 8'h01;
      end else begin
        srst_cnt <= 8'h00;
        reset_output_pin_n_o <= 1'b1;
      end
    end
  end

  // ****************
  // Registered outputs
  // ****************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mode_req_o <= MSC_MODE_NORMAL;
      aux_regulator_on_o <= 1'b0;
      main_reset_threshold_sel_o <= 2'h0;
      restart_req_o <= 1'b0;
      failsafe_req_o <= 1'b0;
      spi_fail_set_o <= 1'b0;
      fail_output_pin_o <= 1'b0;
      charge_pump_enable_o <= 1'b0;
    end else begin
      mode_req_o <= mode_field;
      aux_regulator_on_o <= next_aux_on;
      main_reset_threshold_sel_o <= main_reset_threshold_sel;
      restart_req_o <= go_restart & hw_cfg_restart_i;
      failsafe_req_o <= go_restart & ~hw_cfg_restart_i;
      spi_fail_set_o <= stop_to_normal & low_changed;
      fail_output_pin_o <= next_fail_out;
      charge_pump_enable_o <= charge_pump_enable;
    end
  end
endmodule

// *** msc_mode_supply_regs_assertions.sv ***
// Assertion checker for the mode and supply control registers.
`timescale 1ns/1ps
module msc_regs_chk (
  input wire logic mclk_i, rst_n_i, dev_mode_i, init_mode_i,
  input wire logic restart_mode_i, failsafe_mode_i, restart_entry_i,
  input wire logic overtemp_i, hw_cfg_restart_i, main_ov_flag_clr_i,
  input wire logic failure_i, fo_pin_cfg_i, soft_reset_o,
  input wire logic [1:0] mode_req_o, main_reset_threshold_sel_o,
  input wire logic reset_output_pin_n_o, aux_regulator_on_o,
  input wire logic main_overvoltage_flag_o, restart_req_o, failsafe_req_o,
  input wire logic spi_fail_set_o, fail_output_pin_o
);
  import msc_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_aux_forced_off:
    assert property ((restart_mode_i || failsafe_mode_i ||
      (init_mode_i && !dev_mode_i))[*3] |-> !aux_regulator_on_o)
    else $error("aux regulator on in a forced-off mode");
  chk_restart_entry:
    assert property (restart_entry_i |-> ##3 mode_req_o == MSC_MODE_NORMAL &&
      main_reset_threshold_sel_o == $past(main_reset_threshold_sel_o, 3))
    else $error("restart entry did not restore mode or threshold");
  chk_overtemp_aux:
    assert property (overtemp_i |-> ##3 !aux_regulator_on_o)
    else $error("aux regulator still on after overtemperature");
  chk_ov_flag_sticky:
    assert property ($fell(main_overvoltage_flag_o) |->
      $past(main_ov_flag_clr_i) || $past(main_ov_flag_clr_i, 2))
    else $error("overvoltage flag dropped without a clear");
  chk_reaction_route:
    assert property ((restart_req_o || failsafe_req_o) |->
      restart_req_o == $past(hw_cfg_restart_i))
    else $error("reaction went to the wrong mode");
  chk_failure_holds_fo:
    assert property ((failure_i && fo_pin_cfg_i)[*3] |-> fail_output_pin_o)
    else $error("fail output released while a failure is present");
  chk_no_stop_sleep:
    assert property ($past(mode_req_o) == MSC_MODE_STOP |->
      mode_req_o != MSC_MODE_SLEEP)
    else $error("mode went from stop straight to sleep");
  chk_spi_fail_normal:
    assert property (spi_fail_set_o |-> ##[0:2] mode_req_o == MSC_MODE_NORMAL)
    else $error("serial failure flagged without a move to normal");
  chk_reset_pin_pulse:
    assert property ($fell(reset_output_pin_n_o) |->
      (!reset_output_pin_n_o)[*8] ##[1:20] reset_output_pin_n_o)
    else $error("reset output pulse has the wrong length");
  cov_soft_reset: cover property (soft_reset_o);
  cov_restart_req: cover property (restart_req_o);
  cov_spi_fail: cover property (spi_fail_set_o);
endmodule
bind msc_mode_supply_regs msc_regs_chk chk_i (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .dev_mode_i(dev_mode_i),
  .init_mode_i(init_mode_i),
  .restart_mode_i(restart_mode_i),
  .failsafe_mode_i(failsafe_mode_i),
  .restart_entry_i(restart_entry_i),
  .overtemp_i(overtemp_i),
  .hw_cfg_restart_i(hw_cfg_restart_i),
  .main_ov_flag_clr_i(main_ov_flag_clr_i),
  .failure_i(failure_i),
  .fo_pin_cfg_i(fo_pin_cfg_i),
  .soft_reset_o(soft_reset_o),
  .mode_req_o(mode_req_o),
  .main_reset_threshold_sel_o(main_reset_threshold_sel_o),
  .reset_output_pin_n_o(reset_output_pin_n_o),
  .aux_regulator_on_o(aux_regulator_on_o),
  .main_overvoltage_flag_o(main_overvoltage_flag_o),
  .restart_req_o(restart_req_o),
  .failsafe_req_o(failsafe_req_o),
  .spi_fail_set_o(spi_fail_set_o),
  .fail_output_pin_o(fail_output_pin_o)
);

// *** msc_mode_supply_regs_tb.sv ***
// Self-checking bench for the mode and supply control registers.
`timescale 1ns/1ps
module msc_mode_supply_regs_tb;
  import msc_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i, sclk_i, csn_i, sdi_i, sdo_o, dev_mode_i, init_mode_i;
  logic normal_mode_i, stop_mode_i, restart_mode_i, failsafe_mode_i;
  logic hw_cfg_restart_i, cfg_lock0_i, cfg_lock1_i, main_ov_i;
  logic failure_i, fo_pin_cfg_i, soft_reset_o, reset_output_pin_n_o;
  logic aux_regulator_on_o, main_overvoltage_flag_o, restart_req_o;
  logic failsafe_req_o, spi_fail_set_o, fail_output_pin_o;
  logic charge_pump_enable_o;
  logic [1:0] mode_req_o, main_reset_threshold_sel_o;
  wire restart_entry_i, overtemp_i, main_ov_flag_clr_i, wd_fail_i, wd_ok_i;
  logic [4:0] ev = 5'h00;
  logic [15:0] rnd = 16'hec73;
  logic [7:0] ms, hw, got, km;
  int mismatches = 0, checks_done = 0, n_rst = 0, n_fs = 0, n_sf = 0;
  int n_sr = 0;
  assign {wd_ok_i, wd_fail_i, main_ov_flag_clr_i, overtemp_i,
    restart_entry_i} = ev;
  msc_mode_supply_regs dut (.*);
  msc_spi_master host (.mclk_i(mclk_i), .sclk_o(sclk_i), .csn_o(csn_i),
    .sdi_o(sdi_i), .sdo_i(sdo_o));
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (restart_req_o === 1'b1) n_rst++;
    if (failsafe_req_o === 1'b1) n_fs++;
    if (spi_fail_set_o === 1'b1) n_sf++;
    if (soft_reset_o === 1'b1) n_sr++;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic aux_exp();
    logic on;
    on = ms[4] ? (ms[3] | normal_mode_i | stop_mode_i) : ms[3] & normal_mode_i;
    return on & !restart_mode_i & !failsafe_mode_i &
      !(init_mode_i & !dev_mode_i);
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic outs();
    chk({4'h0, mode_req_o, main_reset_threshold_sel_o},
      {4'h0, ms[7:6], ms[1:0]});
    chk({6'h0, charge_pump_enable_o, aux_regulator_on_o},
      {6'h0, hw[2], aux_exp()});
  endtask
  task automatic rd(input logic [6:0] a);
    host.xfer({8'h00, 1'b0, a}, 9, got);
    chk(got, a == 7'h01 ? ms : a == 7'h02 ? hw : 8'h00);
    outs();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({d, 1'b1, a}, 5, got);
    chk(got, a == 7'h01 ? ms : hw);
    km = {1'b0, cfg_lock1_i, 3'h0, cfg_lock0_i, 2'h0};
    if (a == 7'h02)
      hw = (d & 8'h65 & ~km) | (hw & km);
    else if (d[7:6] == MSC_MODE_SRESET) begin
      ms = 8'h00;
      hw = hw & km;
    // Current device mode decides, not the stored field
    end else if (stop_mode_i && d[7:6] == MSC_MODE_SLEEP)
      ms = {ms[7:6], 1'b0, d[4:0]};
    else if (stop_mode_i && d[7:6] == MSC_MODE_NORMAL)
      ms = {2'h0, ms[5:0]};
    else
      ms = d & 8'hdf;
    outs();
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge mclk_i);
    ev[k] <= 1'b0;
    repeat (5) @(posedge mclk_i);
  endtask
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    ms = dev_mode_i ? 8'h18 : 8'h00;
    hw = 8'h00;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk_i);
    mismatches++;
    test_done();
  end
  initial begin
    {rst_n_i, dev_mode_i, init_mode_i, stop_mode_i, restart_mode_i} = 5'h0;
    {failsafe_mode_i, hw_cfg_restart_i, cfg_lock0_i, cfg_lock1_i} = 4'h0;
    {main_ov_i, failure_i, fo_pin_cfg_i} = 3'h0;
    normal_mode_i = 1'b1;
    @(posedge mclk_i);
    do_reset();
    rd(7'h01);
    rd(7'h02);
    rd(7'h05);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      wr(7'h01, rnd[7:0] & 8'h1f);
      wr(7'h02, rnd[15:8] & 8'h65);
      rd(7'h01);
      rd(7'h02);
    end
    for (int p = 0; p < 8; p++) begin
      {normal_mode_i, stop_mode_i} <= p[2] ? 2'h1 : 2'h2;
      wr(7'h01, {p[2] ? MSC_MODE_STOP : MSC_MODE_NORMAL, 1'b0, p[1:0],
        3'h0});
    end
    {normal_mode_i, stop_mode_i} <= 2'h2;
    wr(7'h01, 8'h18);
    for (int k = 0; k < 4; k++) begin
      {init_mode_i, restart_mode_i, failsafe_mode_i} <= 3'h1 << k;
      repeat (4) @(posedge mclk_i);
      outs();
    end
    wr(7'h01, 8'h40);
    wr(7'h01, 8'h81);
    {normal_mode_i, stop_mode_i} <= 2'h1;
    wr(7'h01, 8'h42);
    wr(7'h01, 8'h0b);
    {normal_mode_i, stop_mode_i} <= 2'h2;
    chk(8'(n_sf), 8'h01);
    wr(7'h01, 8'h57);
    fo_pin_cfg_i <= 1'b1;
    wr(7'h02, 8'h21);
    chk({7'h0, fail_output_pin_o}, 8'h01);
    pulse(0);
    ms = ms & 8'h03;
    hw = hw & 8'hdf;
    rd(7'h01);
    rd(7'h02);
    chk({7'h0, fail_output_pin_o}, 8'h00);
    wr(7'h01, 8'h18);
    pulse(1);
    ms = ms & 8'he7;
    rd(7'h01);
    failure_i <= 1'b1;
    wr(7'h02, 8'h20);
    wr(7'h02, 8'h00);
    chk({7'h0, fail_output_pin_o}, 8'h01);
    {failure_i, fo_pin_cfg_i} <= 2'h0;
    wr(7'h02, 8'h20);
    chk({7'h0, fail_output_pin_o}, 8'h00);
    wr(7'h01, 8'h04);
    for (int k = 0; k < 3; k++) begin
      if (k == 2)
        wr(7'h01, 8'h00);
      hw_cfg_restart_i <= k[0];
      main_ov_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      chk({7'h0, main_overvoltage_flag_o}, 8'h01);
      main_ov_i <= 1'b0;
      pulse(2);
      chk({7'h0, main_overvoltage_flag_o}, 8'h00);
    end
    chk(8'(n_fs), 8'h01);
    chk(8'(n_rst), 8'h01);
    hw_cfg_restart_i <= 1'b1;
    pulse(3);
    pulse(4);
    pulse(3);
    chk(8'(n_rst), 8'h01);
    pulse(3);
    chk(8'(n_rst), 8'h02);
    wr(7'h02, 8'h01);
    pulse(3);
    chk(8'(n_rst), 8'h03);
    wr(7'h02, 8'h44);
    {cfg_lock0_i, cfg_lock1_i} <= 2'h3;
    for (int k = 0; k < 2; k++) begin
      wr(7'h02, 8'h00);
      wr(7'h01, 8'hc0);
      chk({7'h0, reset_output_pin_n_o}, {7'h0, hw[6]});
      repeat (25) @(posedge mclk_i);
      chk({7'h0, reset_output_pin_n_o}, 8'h01);
      rd(7'h02);
      {cfg_lock0_i, cfg_lock1_i} <= 2'h0;
    end
    {dev_mode_i, init_mode_i} <= 2'h3;
    do_reset();
    rd(7'h01);
    wr(7'h01, 8'hc0);
    rd(7'h01);
    chk(8'(n_sr), 8'h03);
    test_done();
  end
endmodule

// *** msc_pkg.sv ***
// Package for the mode and supply control register pair.
package msc_pkg;

  // ****************
  // Register map
  // ****************
  localparam logic [6:0] MSC_ADDR_MODE_SUPPLY = 7'h01;
  localparam logic [6:0] MSC_ADDR_HW_CTRL_LOW = 7'h02;

  // ****************
  // Field positions, mode and supply register
  // ****************
  localparam int MSC_MODE_HI = 7;
  localparam int MSC_MODE_LO = 6;
  localparam int MSC_AUX_HI = 4;
  localparam int MSC_AUX_LO = 3;
  localparam int MSC_OVR_BIT = 2;
  localparam int MSC_RT_HI = 1;
  localparam int MSC_RT_LO = 0;

  // ****************
  // Field positions, hardware control register
  // ****************
  localparam int MSC_SRST_BIT = 6;
  localparam int MSC_FO_BIT = 5;
  localparam int MSC_CP_BIT = 2;
  localparam int MSC_WDSEL_BIT = 0;

  // ****************
  // Values after reset
  // ****************
  localparam logic [7:0] MSC_MODE_SUPPLY_RST = 8'h00;
  localparam logic [7:0] MSC_HW_CTRL_LOW_RST = 8'h00;
  localparam logic [1:0] MSC_AUX_DEV_RST = 2'h3;

  // ****************
  // Field encodings
  // ****************
  localparam logic [1:0] MSC_MODE_NORMAL = 2'h0;
  localparam logic [1:0] MSC_MODE_SLEEP = 2'h1;
  localparam logic [1:0] MSC_MODE_STOP = 2'h2;
  localparam logic [1:0] MSC_MODE_SRESET = 2'h3;
  localparam logic [1:0] MSC_AUX_OFF = 2'h0;
  localparam logic [1:0] MSC_AUX_NORMAL = 2'h1;
  localparam logic [1:0] MSC_AUX_NORM_STOP = 2'h2;
  localparam logic [1:0] MSC_AUX_ALWAYS = 2'h3;

  // ****************
  // Frame and timing
  // ****************
  localparam int MSC_FRAME_BITS = 16;
  localparam int MSC_CLK_HZ = 20000000;
  localparam int MSC_SRST_PULSE_NS = 1000;
  localparam int MSC_SRST_PULSE_CYC =
    (MSC_SRST_PULSE_NS * (MSC_CLK_HZ / 1000000) + 999) / 1000;

  typedef struct packed {
    logic [7:0] data;
    logic write;
    logic [6:0] addr;
  } msc_frame_t;

endpackage

// *** msc_spi_master.sv ***
// Controller model that sends serial frames to the register block.
`timescale 1ns/1ps
module msc_spi_master (
  // Clock
  input wire logic mclk_i,
  // Serial pins
  output logic sclk_o,
  output logic csn_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    sdi_o = 1'b0;
  end
  // One frame, LSB first; ph is each clock phase in mclk cycles
  task automatic xfer(input logic [15:0] f, input int ph,
    output logic [7:0] rd);
    csn_o <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdi_o <= f[i];
      repeat (ph) @(posedge mclk_i);
      if (i > 7)
        rd[i-8] = sdo_i;
      sclk_o <= 1'b1;
      repeat (ph) @(posedge mclk_i);
      sclk_o <= 1'b0;
    end
    repeat (ph) @(posedge mclk_i);
    csn_o <= 1'b1;
    sdi_o <= ~f[15];
    repeat (ph) @(posedge mclk_i);
  endtask
endmodule

// *** msc_spi_slave.sv ***
// Serial frame engine: shifts 16-bit frames in and read data out.
`timescale 1ns/1ps
module msc_spi_slave (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic sdi_i,
  output logic sdo_o,
  // Register side
  input wire logic [7:0] rd_data_i,
  output logic [6:0] rd_addr_o,
  output msc_pkg::msc_frame_t frame_o,
  output logic frame_valid_o
);
  import msc_pkg::*;

  logic sclk_q;
  logic csn_q;
  logic [15:0] shift_q;
  logic [4:0] count_q;
  logic [7:0] tx_q;
  logic load_q;

  wire sclk_rise = sclk_i & ~sclk_q;
  wire sclk_fall = ~sclk_i & sclk_q;
  wire csn_rise = csn_i & ~csn_q;
  wire full_frame = (count_q == 5'(MSC_FRAME_BITS));

  // Address byte lands in the upper half after eight bits
  assign rd_addr_o = shift_q[14:8];

  always_ff @(posedge mclk_i) begin
    sclk_q <= sclk_i;
    csn_q <= csn_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
      tx_q <= 8'h00;
      load_q <= 1'b0;
      sdo_o <= 1'b0;
      frame_o <= '0;
      frame_valid_o <= 1'b0;
    end else begin
      frame_valid_o <= 1'b0;
      load_q <= 1'b0;
      if (csn_i) begin
        count_q <= 5'h00;
        sdo_o <= 1'b0;
        if (csn_rise && full_frame) begin
          frame_o <= shift_q;
          frame_valid_o <= 1'b1;
        end
      end else begin
        if (sclk_rise) begin
          shift_q <= {sdi_i, shift_q[15:1]};
          if (count_q != 5'h1f) begin
            count_q <= count_q + 5'h01;
          end
          load_q <= (count_q == 5'h07);
        end
        // Contents sampled before any write of this frame lands
        if (load_q) begin
          tx_q <= rd_data_i;
        end
        if (sclk_fall && count_q >= 5'h08) begin
          sdo_o <= tx_q[0];
          tx_q <= {1'b0, tx_q[7:1]};
        end
      end
    end
  end
endmodule
